// file: pkg/trig_tx_pkg.sv
/*
 Constants, register map and carrier types for the host-to-camera trigger
 transmitter. Assumes a single 200 MHz clock domain.
*/
`default_nettype none
package trig_tx_pkg;
   // Clock and link timing
   localparam int CLK_PERIOD_NS  = 5;
   localparam int CHAR_FAST_NS   = 240;
   localparam int CHAR_SLOW_NS   = 480;
   localparam int CHAR_FAST_CYC  = CHAR_FAST_NS / CLK_PERIOD_NS;
   localparam int CHAR_SLOW_CYC  = CHAR_SLOW_NS / CLK_PERIOD_NS;
   localparam int PIPE_CHARS     = 4;
   localparam int MSG_CHARS      = 6;
   // Delay unit: 1 ns fast, 2 ns slow
   localparam int UNIT_FAST_NS   = 1;
   localparam int UNIT_SLOW_NS   = 2;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_ACKLIM  = 8'h04;
   localparam logic [7:0] ADDR_RESEND  = 8'h08;
   localparam logic [7:0] ADDR_STATUS  = 8'h0C;
   localparam logic [7:0] ADDR_DELAY   = 8'h10;
   // Control fields
   localparam int CTRL_FMT_LSB   = 0;
   localparam int CTRL_FAST_BIT  = 2;
   localparam int CTRL_LEVEL_BIT = 3;
   // Status fields
   localparam int ST_BUSY_BIT    = 0;
   localparam int ST_ACK_BIT     = 1;
   localparam int ST_RESEND_BIT  = 2;
   localparam int ST_ABORT_BIT   = 3;
   localparam int ST_LEVEL_BIT   = 4;
   // Reset values and AXI response codes
   localparam logic [31:0] ACKLIM_RST_NS = 32'h0000_4E20; // 20.0 us
   localparam logic [3:0]  RESEND_RST    = 4'h3;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef enum logic [1:0] {
      FMT_PULSE, FMT_RISING_ONLY, FMT_TOGGLE, FMT_RSVD
   } msg_fmt_t;

   // Trigger packet handed to the up-connection serializer
   typedef struct packed {
      logic       kind;   // 0 LinkTrigger0, 1 LinkTrigger1
      logic [7:0] delay;  // Event to next character boundary, 1/24 bit units
   } trig_pkt_t;
endpackage
`default_nettype wire

// file: rtl/trig_tx.sv
/*
 Host-to-camera trigger transmitter with AXI4-Lite register slave.
 Assumes trig_src is asynchronous, ack_in and the packet port are on aclk.
*/
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module trig_tx
   import trig_tx_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // Trigger source and camera side
   input  wire logic        trig_src,
   input  wire logic        ack_in,
   output trig_pkt_t        pkt,
   output logic             pkt_start,
   output logic             link_busy,
   // Events
   output logic             ack_received_event,
   output logic             resend_event
);
   typedef enum logic [2:0] {S_IDLE, S_ALIGN, S_PIPE, S_SEND, S_WAIT} st_t;

   // Registers
   logic [1:0]  fmt_ff, nxt_fmt;
   logic        fast_ff, nxt_fast;
   logic        sw_level_ff, nxt_sw_level;
   logic [31:0] acklim_ff, nxt_acklim;
   logic [3:0]  maxres_ff, nxt_maxres;
   logic        st_ack_ff, nxt_st_ack, st_res_ff, nxt_st_res, st_abt_ff, nxt_st_abt;
   // AXI state
   logic        aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got, bvalid_ff, nxt_bvalid;
   logic [7:0]  awaddr_ff, nxt_awaddr;
   logic [31:0] wdata_ff, nxt_wdata;
   logic [3:0]  wstrb_ff, nxt_wstrb;
   logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic        rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   // Transmitter state
   logic        sync1_ff, sync2_ff, lvl_ff;
   logic        level;
   st_t         st_ff, nxt_st;
   logic [6:0]  char_cyc_ff, nxt_char_cyc;
   logic [3:0]  chars_ff, nxt_chars;
   logic [9:0]  dly_ns_ff, nxt_dly_ns;
   logic [31:0] wait_ns_ff, nxt_wait_ns;
   logic [3:0]  tries_ff, nxt_tries;
   logic        tog_ff, nxt_tog;
   logic        kind_ff, nxt_kind;
   trig_pkt_t   pkt_ff, nxt_pkt;
   logic        start_ff, nxt_start, ack_ev_ff, nxt_ack_ev, res_ev_ff, nxt_res_ev;
   logic        char_tick, rise, fall;
   logic [6:0]  char_last;

   // Byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Source level: pin or software level; pin synchronised first
   assign level = sync2_ff | sw_level_ff;
   assign rise  = level & ~lvl_ff;
   assign fall  = ~level & lvl_ff;
   // Character clock free-runs so boundaries are fixed on the link
   assign char_last = fast_ff ? 7'(CHAR_FAST_CYC - 1) : 7'(CHAR_SLOW_CYC - 1);
   assign char_tick = (char_cyc_ff == char_last);

   // Register file and AXI next state
   always_comb begin
      logic [31:0] wv;
      wv = 32'h0000_0000;
      nxt_fmt = fmt_ff;
      nxt_fast = fast_ff;
      nxt_sw_level = sw_level_ff;
      nxt_acklim = acklim_ff;
      nxt_maxres = maxres_ff;
      nxt_aw_got = aw_got_ff;
      nxt_w_got = w_got_ff;
      nxt_awaddr = awaddr_ff;
      nxt_wdata = wdata_ff;
      nxt_wstrb = wstrb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      nxt_st_ack = st_ack_ff;
      nxt_st_res = st_res_ff;
      nxt_st_abt = st_abt_ff;
      if (s_awvalid && s_awready) begin
         nxt_aw_got = 1'b1;
         nxt_awaddr = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         nxt_w_got = 1'b1;
         nxt_wdata = s_wdata;
         nxt_wstrb = s_wstrb;
      end
      if (bvalid_ff && s_bready) begin
         nxt_bvalid = 1'b0;
      end
      // Write commits once both halves are held
      if (aw_got_ff && w_got_ff && !bvalid_ff) begin
         nxt_aw_got = 1'b0;
         nxt_w_got = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = RESP_OKAY;
         unique case (awaddr_ff)
            ADDR_CTRL: begin
               wv = merge({28'h0, sw_level_ff, fast_ff, fmt_ff}, wdata_ff, wstrb_ff);
               nxt_fmt = wv[CTRL_FMT_LSB +: 2];
               nxt_fast = wv[CTRL_FAST_BIT];
               nxt_sw_level = wv[CTRL_LEVEL_BIT];
            end
            ADDR_ACKLIM: nxt_acklim = merge(acklim_ff, wdata_ff, wstrb_ff);
            ADDR_RESEND: begin
               wv = merge({28'h0, maxres_ff}, wdata_ff, wstrb_ff);
               nxt_maxres = wv[3:0];
            end
            ADDR_STATUS: begin
               // Write one to clear
               if (wstrb_ff[0]) begin
                  nxt_st_ack = st_ack_ff & ~wdata_ff[ST_ACK_BIT];
                  nxt_st_res = st_res_ff & ~wdata_ff[ST_RESEND_BIT];
                  nxt_st_abt = st_abt_ff & ~wdata_ff[ST_ABORT_BIT];
               end
            end
            ADDR_DELAY: ;
            default: nxt_bresp = RESP_SLVERR;
         endcase
      end
      // Hardware set wins over a same-cycle clear
      if (ack_ev_ff) begin
         nxt_st_ack = 1'b1;
      end
      if (res_ev_ff) begin
         nxt_st_res = 1'b1;
      end
      if (st_ff == S_WAIT && nxt_st == S_IDLE && !ack_in) begin
         nxt_st_abt = 1'b1;
      end
      if (rvalid_ff && s_rready) begin
         nxt_rvalid = 1'b0;
      end
      if (s_arvalid && s_arready) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = RESP_OKAY;
         unique case (s_araddr)
            ADDR_CTRL:   nxt_rdata = {28'h0, sw_level_ff, fast_ff, fmt_ff};
            ADDR_ACKLIM: nxt_rdata = acklim_ff;
            ADDR_RESEND: nxt_rdata = {28'h0, maxres_ff};
            ADDR_STATUS: nxt_rdata = {27'h0, level, st_abt_ff, st_res_ff, st_ack_ff,
                                      (st_ff != S_IDLE)};
            ADDR_DELAY:  nxt_rdata = {23'h0, pkt_ff};
            default: begin
               nxt_rdata = 32'h0000_0000;
               nxt_rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   assign s_awready = !aw_got_ff;
   assign s_wready  = !w_got_ff;
   assign s_bvalid  = bvalid_ff;
   assign s_bresp   = bresp_ff;
   assign s_arready = !rvalid_ff;
   assign s_rvalid  = rvalid_ff;
   assign s_rdata   = rdata_ff;
   assign s_rresp   = rresp_ff;

   // Transmitter next state
   always_comb begin
      nxt_st = st_ff;
      nxt_char_cyc = char_tick ? 7'h00 : 7'(char_cyc_ff + 7'h01);
      nxt_chars = chars_ff;
      nxt_dly_ns = dly_ns_ff;
      nxt_wait_ns = wait_ns_ff;
      nxt_tries = tries_ff;
      nxt_tog = tog_ff;
      nxt_kind = kind_ff;
      nxt_pkt = pkt_ff;
      nxt_start = 1'b0;
      nxt_ack_ev = 1'b0;
      nxt_res_ev = 1'b0;
      unique case (st_ff)
         S_IDLE: begin
            // Edges while busy are dropped
            if (rise && fmt_ff != FMT_RSVD) begin
               nxt_st = S_ALIGN;
               nxt_dly_ns = 10'h000;
               nxt_tries = 4'h0;
               unique case (fmt_ff)
                  FMT_PULSE:       nxt_kind = 1'b0;
                  FMT_RISING_ONLY: nxt_kind = 1'b0;
                  FMT_TOGGLE: begin
                     nxt_kind = tog_ff;
                     nxt_tog = ~tog_ff;
                  end
                  default:         nxt_kind = 1'b0;
               endcase
            end else if (fall && fmt_ff == FMT_PULSE) begin
               nxt_st = S_ALIGN;
               nxt_dly_ns = 10'h000;
               nxt_tries = 4'h0;
               nxt_kind = 1'b1;
            end
         end
         S_ALIGN: begin
            // Count event-to-boundary time in ns
            nxt_dly_ns = 10'(dly_ns_ff + 10'(CLK_PERIOD_NS));
            if (char_tick) begin
               nxt_st = S_PIPE;
               nxt_chars = 4'h0;
               nxt_pkt.kind = kind_ff;
               // Convert ns to 1/24 bit units
               nxt_pkt.delay = fast_ff ? 8'(dly_ns_ff / UNIT_FAST_NS)
                                       : 8'(dly_ns_ff / UNIT_SLOW_NS);
            end
         end
         S_PIPE: begin
            if (char_tick) begin
               if (chars_ff == 4'(PIPE_CHARS - 1)) begin
                  nxt_st = S_SEND;
                  nxt_chars = 4'h0;
                  nxt_start = 1'b1;
               end else begin
                  nxt_chars = 4'(chars_ff + 4'h1);
               end
            end
         end
         S_SEND: begin
            if (char_tick) begin
               if (chars_ff == 4'(MSG_CHARS - 1)) begin
                  nxt_wait_ns = 32'h0000_0000;
                  // Zero limit: done on send, fastest rate path
                  nxt_st = (acklim_ff == 32'h0) ? S_IDLE : S_WAIT;
               end else begin
                  nxt_chars = 4'(chars_ff + 4'h1);
               end
            end
         end
         S_WAIT: begin
            nxt_wait_ns = 32'(wait_ns_ff + 32'(CLK_PERIOD_NS));
            if (ack_in) begin
               nxt_st = S_IDLE;
               nxt_ack_ev = 1'b1;
            end else if (wait_ns_ff >= acklim_ff) begin
               if (tries_ff < maxres_ff) begin
                  nxt_st = S_ALIGN;
                  nxt_tries = 4'(tries_ff + 4'h1);
                  nxt_res_ev = 1'b1;
                  nxt_dly_ns = 10'h000;
               end else begin
                  nxt_st = S_IDLE;
               end
            end
         end
      endcase
   end

   assign pkt = pkt_ff;
   assign pkt_start = start_ff;
   assign link_busy = (st_ff == S_SEND);
   assign ack_received_event = ack_ev_ff;
   assign resend_event = res_ev_ff;

   // Register all state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fmt_ff <= FMT_PULSE;
         fast_ff <= 1'b0;
         sw_level_ff <= 1'b0;
         acklim_ff <= ACKLIM_RST_NS;
         maxres_ff <= RESEND_RST;
         st_ack_ff <= 1'b0;
         st_res_ff <= 1'b0;
         st_abt_ff <= 1'b0;
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         lvl_ff <= 1'b0;
         st_ff <= S_IDLE;
         char_cyc_ff <= 7'h00;
         chars_ff <= 4'h0;
         dly_ns_ff <= 10'h000;
         wait_ns_ff <= 32'h0000_0000;
         tries_ff <= 4'h0;
         tog_ff <= 1'b0;
         kind_ff <= 1'b0;
         pkt_ff <= '0;
         start_ff <= 1'b0;
         ack_ev_ff <= 1'b0;
         res_ev_ff <= 1'b0;
      end else begin
         fmt_ff <= nxt_fmt;
         fast_ff <= nxt_fast;
         sw_level_ff <= nxt_sw_level;
         acklim_ff <= nxt_acklim;
         maxres_ff <= nxt_maxres;
         st_ack_ff <= nxt_st_ack;
         st_res_ff <= nxt_st_res;
         st_abt_ff <= nxt_st_abt;
         aw_got_ff <= nxt_aw_got;
         w_got_ff <= nxt_w_got;
         awaddr_ff <= nxt_awaddr;
         wdata_ff <= nxt_wdata;
         wstrb_ff <= nxt_wstrb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
         sync1_ff <= trig_src;
         sync2_ff <= sync1_ff;
         lvl_ff <= level;
         st_ff <= nxt_st;
         char_cyc_ff <= nxt_char_cyc;
         chars_ff <= nxt_chars;
         dly_ns_ff <= nxt_dly_ns;
         wait_ns_ff <= nxt_wait_ns;
         tries_ff <= nxt_tries;
         tog_ff <= nxt_tog;
         kind_ff <= nxt_kind;
         pkt_ff <= nxt_pkt;
         start_ff <= nxt_start;
         ack_ev_ff <= nxt_ack_ev;
         res_ev_ff <= nxt_res_ev;
      end
   end
endmodule
`default_nettype wire

// file: testbench/cam_model.sv
/*
 Camera end of the trigger link: acknowledges each message.
 Assumes ack_in is sampled on aclk by the transmitter.
*/
`timescale 1ns/1ps
`default_nettype none
module cam_model (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Link side
   input  wire logic       link_busy,
   input  wire logic       ack_en,
   input  wire logic [7:0] ack_lat,
   output logic            ack_in
);
   logic busy_q;
   int   cnt;

   // Answer once the message has left; a deaf camera stays quiet
   always @(posedge aclk) begin
      busy_q <= link_busy;
      ack_in <= 1'b0;
      if (!aresetn)
         cnt <= -1;
      else if (busy_q && !link_busy && ack_en)
         cnt <= ack_lat;
      else if (cnt == 0) begin
         ack_in <= 1'b1;
         cnt <= -1;
      end
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
endmodule
`default_nettype wire

// file: testbench/tb_trig_tx.sv
/*
 Self-checking bench for the trigger transmitter with a camera model.
 Assumes a 200 MHz aclk and an AXI4-Lite master in the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_trig_tx
   import trig_tx_pkg::*;
;
   logic        aclk, aresetn, trig_src, ack_in, pkt_start, link_busy, ack_en;
   logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic        s_arvalid, s_arready, s_rvalid, s_rready;
   logic        ack_received_event, resend_event, ek;
   logic [7:0]  s_awaddr, s_araddr, ack_lat;
   logic [31:0] s_wdata, s_rdata, d, v;
   logic [3:0]  s_wstrb;
   logic [1:0]  s_bresp, s_rresp, r;
   trig_pkt_t   pkt;
   logic        q_kind[$];
   int          num_errors, checked, ack_n, resend_n, seed, i;

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end

   trig_tx uut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
      .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
      .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .trig_src,
      .ack_in, .pkt, .pkt_start, .link_busy, .ack_received_event, .resend_event);
   cam_model cam (.aclk, .aresetn, .link_busy, .ack_en, .ack_lat, .ack_in);

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic report_and_stop();
      $display("checked %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw, w, da, dw;
      s_awaddr <= a;
      s_wdata <= v;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      da = 1'b0;
      dw = 1'b0;
      while (!(da && dw)) begin
         #1 aw = s_awvalid && s_awready;
         w = s_wvalid && s_wready;
         @(posedge aclk);
         if (aw) s_awvalid <= 1'b0;
         if (w) s_wvalid <= 1'b0;
         da = da | aw;
         dw = dw | w;
      end
      // Late ready lets the slave hold its answer for a while
      repeat (2) @(posedge aclk);
      s_bready <= 1'b1;
      do begin
         #1 aw = s_bvalid;
         @(posedge aclk);
      end while (!aw);
      s_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      logic t;
      s_araddr <= a;
      s_arvalid <= 1'b1;
      do begin
         #1 t = s_arready;
         @(posedge aclk);
      end while (!t);
      s_arvalid <= 1'b0;
      @(posedge aclk);
      s_rready <= 1'b1;
      do begin
         #1 t = s_rvalid;
         d = s_rdata;
         r = s_rresp;
         @(posedge aclk);
      end while (!t);
      s_rready <= 1'b0;
   endtask

   task automatic idle();
      do rd(ADDR_STATUS); while (d[ST_BUSY_BIT] !== 1'b0);
   endtask

   // Random gap moves the edge against the character grid
   task automatic edge_to(input logic v);
      repeat ($unsigned($random(seed)) % 97) @(posedge aclk);
      trig_src <= v;
      repeat (8) @(posedge aclk);
      idle();
   endtask

   // Reference model: looks mid-cycle so registered outputs have settled
   always @(negedge aclk) begin
      if (aresetn && pkt_start) begin
         ek = (q_kind.size() == 0) ? 1'bx : q_kind.pop_front();
         `CHK("pkt_kind", ek, pkt.kind)
         // Camera delays by the rest of one character, so the value must fit in it
         `CHK("pkt_delay_ok", 1'b1, pkt.delay <= 8'hF0)
      end
      if (ack_received_event === 1'b1) ack_n++;
      if (resend_event === 1'b1) resend_n++;
   end

   initial begin
      repeat (60000) @(posedge aclk);
      num_errors++;
      $display("BAD watchdog expired");
      report_and_stop();
   end

   initial begin
      seed = 32'hF8AA25DC;
      {aresetn, trig_src, ack_en, s_awvalid, s_wvalid, s_bready} = 6'h00;
      {s_arvalid, s_rready} = 2'h0;
      {s_awaddr, s_araddr, ack_lat} = 24'h000000;
      {s_wdata, s_wstrb} = 36'hF_0000_0000;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(ADDR_CTRL);
      `CHK("ctrl_rst", 32'h0000_0000, d)
      rd(ADDR_ACKLIM);
      `CHK("acklim_rst", 32'h0000_4E20, d)
      rd(ADDR_RESEND);
      `CHK("resend_rst", 4'h3, d[3:0])
      rd(8'hFC);
      `CHK("unmapped", RESP_SLVERR, r)
      // Partial write: only the low byte lane may change
      v = $random(seed);
      s_wstrb <= 4'h1;
      wr(ADDR_ACKLIM, v);
      s_wstrb <= 4'hF;
      rd(ADDR_ACKLIM);
      `CHK("acklim_lane", {ACKLIM_RST_NS[31:8], v[7:0]}, d)
      // Toggle on slow link, no acknowledge wait
      wr(ADDR_ACKLIM, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_0002);
      for (i = 0; i < 4; i++) begin
         q_kind.push_back(i[0]);
         edge_to(1'b1);
         edge_to(1'b0);
      end
      // Pulse on fast link
      wr(ADDR_CTRL, 32'h0000_0004);
      for (i = 0; i < 2; i++) begin
         q_kind.push_back(1'b0);
         edge_to(1'b1);
         q_kind.push_back(1'b1);
         edge_to(1'b0);
      end
      // Rising only; second rise falls inside the first transaction
      wr(ADDR_CTRL, 32'h0000_0005);
      q_kind.push_back(1'b0);
      trig_src <= 1'b1;
      repeat (20) @(posedge aclk);
      trig_src <= 1'b0;
      repeat (20) @(posedge aclk);
      trig_src <= 1'b1;
      idle();
      edge_to(1'b0);
      // Software level acts as a rising edge
      q_kind.push_back(1'b0);
      wr(ADDR_CTRL, 32'h0000_000D);
      repeat (8) @(posedge aclk);
      idle();
      `CHK("level_st", 1'b1, d[ST_LEVEL_BIT])
      rd(ADDR_CTRL);
      `CHK("ctrl_rd", 4'hD, d[3:0])
      // Dropping the level in pulse format is a falling edge
      q_kind.push_back(1'b1);
      wr(ADDR_CTRL, 32'h0000_0000);
      repeat (8) @(posedge aclk);
      idle();
      // Acknowledged, then unanswered with two resends
      wr(ADDR_ACKLIM, 32'h0000_0064);
      wr(ADDR_RESEND, 32'h0000_0002);
      wr(ADDR_STATUS, 32'h0000_000E);
      ack_en <= 1'b1;
      ack_lat <= 8'h0A;
      q_kind.push_back(1'b0);
      edge_to(1'b1);
      `CHK("ack_n", 1, ack_n)
      ack_en <= 1'b0;
      repeat (3) q_kind.push_back(1'b1);
      edge_to(1'b0);
      `CHK("resend_n", 2, resend_n)
      rd(ADDR_STATUS);
      `CHK("status", 3'h7, d[3:1])
      `CHK("queue_left", 0, q_kind.size())
      report_and_stop();
   end
endmodule
`default_nettype wire

// file: testbench/trig_tx_checker.sv
/*
 Port assertions for the trigger transmitter.
 Assumes one aclk domain and bind onto trig_tx.
*/
`timescale 1ns/1ps
`default_nettype none
module trig_tx_checker
   import trig_tx_pkg::*;
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus answers
   input wire logic        s_bvalid,
   input wire logic        s_bready,
   input wire logic [1:0]  s_bresp,
   input wire logic        s_rvalid,
   input wire logic        s_rready,
   input wire logic [31:0] s_rdata,
   // Link side
   input wire logic        ack_in,
   input wire trig_pkt_t   pkt,
   input wire logic        pkt_start,
   input wire logic        link_busy,
   input wire logic        ack_received_event,
   input wire logic        resend_event
);
   logic [9:0] busy_run_ff;
   logic [9:0] nxt_busy_run;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Length of the running link_busy stretch, one cycle of slack
   always_comb nxt_busy_run = link_busy ? busy_run_ff + 10'h001 : 10'h000;
   always_ff @(posedge aclk) busy_run_ff <= aresetn ? nxt_busy_run : 10'h000;

   start_pulse_a: assert property (pkt_start |=> !pkt_start)
      else $error("packet start longer than one cycle");
   no_overlap_a: assert property (pkt_start |-> !$past(link_busy))
      else $error("packet started over a message on the link");
   busy_len_a: assert property ($fell(link_busy) |->
      busy_run_ff inside {[10'h11F:10'h121], [10'h23F:10'h241]})
      else $error("message time is not six characters");
   start_busy_a: assert property (pkt_start |-> ##[0:1] link_busy)
      else $error("link not busy after packet start");
   pkt_hold_a: assert property (link_busy |-> $stable(pkt))
      else $error("packet changed while on the link");
   delay_max_a: assert property (pkt_start |-> pkt.delay <= 8'hF0)
      else $error("delay beyond one character");
   ack_cause_a: assert property (ack_received_event |-> $past(ack_in) && !link_busy)
      else $error("ack event without acknowledge");
   resend_go_a: assert property (resend_event |-> ##[1:600] pkt_start)
      else $error("resend without a new packet");
   bresp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("write answer dropped early");
   rdata_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read answer dropped early");
endmodule

bind trig_tx trig_tx_checker chk (
   .aclk, .aresetn, .s_bvalid, .s_bready, .s_bresp, .s_rvalid, .s_rready,
   .s_rdata, .ack_in, .pkt, .pkt_start, .link_busy, .ack_received_event,
   .resend_event
);
`default_nettype wire
